/* File: verilog/nfc_pkg.sv */
// nfc_pkg: constants, command codes and carrier types for the nor flash command controller
// assumes a 10 MHz core clock and a word/byte wide asynchronous nor flash outside
package nfc_pkg;
  localparam int NFC_ADDR_W = 20;
  localparam int NFC_DATA_W = 16;
  // software register offsets
  localparam logic [3:0] NFC_REG_CTRL = 4'h0;
  localparam logic [3:0] NFC_REG_ADDR = 4'h1;
  localparam logic [3:0] NFC_REG_DATA = 4'h2;
  localparam logic [3:0] NFC_REG_STAT = 4'h3;
  localparam logic [3:0] NFC_REG_RDAT = 4'h4;
  // control register fields
  localparam int NFC_CTRL_GO = 4;
  localparam int NFC_CTRL_BYTE = 5;
  localparam logic [3:0] NFC_OP_READ = 4'h0;
  localparam logic [3:0] NFC_OP_RESET = 4'h1;
  localparam logic [3:0] NFC_OP_IDENT = 4'h2;
  localparam logic [3:0] NFC_OP_CFI = 4'h3;
  localparam logic [3:0] NFC_OP_PROG = 4'h4;
  localparam logic [3:0] NFC_OP_BYP_ENTER = 4'h5;
  localparam logic [3:0] NFC_OP_BYP_PROG = 4'h6;
  localparam logic [3:0] NFC_OP_BYP_EXIT = 4'h7;
  localparam logic [3:0] NFC_OP_CHIP_ERASE = 4'h8;
  localparam logic [3:0] NFC_OP_SECT_ERASE = 4'h9;
  localparam logic [3:0] NFC_OP_SUSPEND = 4'hA;
  localparam logic [3:0] NFC_OP_RESUME = 4'hB;
  localparam logic [3:0] NFC_OP_SECT_ADD = 4'hC;
  localparam logic [3:0] NFC_OP_BYP_EXIT1 = 4'hD;
  // command data values
  localparam logic [7:0] NFC_D_RESET = 8'hF0;
  localparam logic [7:0] NFC_D_UNLOCK1 = 8'hAA;
  localparam logic [7:0] NFC_D_UNLOCK2 = 8'h55;
  localparam logic [7:0] NFC_D_IDENT = 8'h90;
  localparam logic [7:0] NFC_D_CFI = 8'h98;
  localparam logic [7:0] NFC_D_PROG = 8'hA0;
  localparam logic [7:0] NFC_D_BYPASS = 8'h20;
  localparam logic [7:0] NFC_D_SETUP = 8'h80;
  localparam logic [7:0] NFC_D_CHIP = 8'h10;
  localparam logic [7:0] NFC_D_SECTOR = 8'h30;
  localparam logic [7:0] NFC_D_SUSPEND = 8'hB0;
  localparam logic [7:0] NFC_D_RESUME = 8'h30;
  // command addresses, word and byte mode
  localparam logic [11:0] NFC_A_W1 = 12'h555;
  localparam logic [11:0] NFC_A_W2 = 12'h2AA;
  localparam logic [11:0] NFC_A_B1 = 12'hAAA;
  localparam logic [11:0] NFC_A_B2 = 12'h555;
  localparam logic [11:0] NFC_A_CFI_W = 12'h055;
  localparam logic [11:0] NFC_A_CFI_B = 12'h0AA;
  localparam int NFC_SECT_LSB = 12;
  // bus timing, each phase at least one 100 ns cycle
  localparam int NFC_CLK_NS = 100;
  localparam int NFC_PHASE_NS = 100;
  localparam int NFC_PHASE_CYC = (NFC_PHASE_NS + NFC_CLK_NS - 1) / NFC_CLK_NS;
  localparam int NFC_WINDOW_US = 50;
  localparam int NFC_WINDOW_CYC = NFC_WINDOW_US * 1000 / NFC_CLK_NS;
  localparam int NFC_MAX_CYC = 6;
  // one bus cycle toward the flash
  typedef struct packed {
    logic wr;
    logic [NFC_ADDR_W-1:0] addr;
    logic [7:0] data;
  } nfc_cycle_type;
  // pins toward the flash
  typedef struct packed {
    logic ce_n;
    logic we_n;
    logic oe_n;
    logic [NFC_ADDR_W-1:0] addr;
    logic [NFC_DATA_W-1:0] dq;
    logic dq_oe;
  } nfc_pins_type;
endpackage : nfc_pkg

/* File: verilog/nfc_seq_rom.sv */
// nfc_seq_rom: registered lookup of one bus cycle of a command sequence
// assumes the caller holds op, step and mode stable for one cycle before use
`timescale 1ns/10ps
`default_nettype none
module nfc_seq_rom
  import nfc_pkg::*;
(
  input wire logic core_clk_in,
  input wire logic [3:0] op_in,
  input wire logic [2:0] step_in,
  input wire logic byte_mode_in,
  input wire logic [NFC_ADDR_W-1:0] user_addr_in,
  input wire logic [7:0] user_data_in,
  output nfc_cycle_type cycle_out,
  output logic [2:0] length_out
);
  nfc_cycle_type c;
  logic [2:0] len;
  logic [NFC_ADDR_W-1:0] a1, a2;
  // unlock addresses by bus width
  assign a1 = byte_mode_in ? NFC_ADDR_W'(NFC_A_B1) : NFC_ADDR_W'(NFC_A_W1);
  assign a2 = byte_mode_in ? NFC_ADDR_W'(NFC_A_B2) : NFC_ADDR_W'(NFC_A_W2);
  // table of sequence cycles
  always_comb begin
    c = '{wr: 1'b1, addr: '0, data: NFC_D_RESET};
    len = 3'd1;
    unique case (op_in)
      NFC_OP_READ: begin
        c = '{wr: 1'b0, addr: user_addr_in, data: 8'h00};
      end
      NFC_OP_RESET: begin
        c = '{wr: 1'b1, addr: '0, data: NFC_D_RESET};
      end
      NFC_OP_CFI: begin
        c = '{wr: 1'b1, addr: byte_mode_in ? NFC_ADDR_W'(NFC_A_CFI_B) : NFC_ADDR_W'(NFC_A_CFI_W),
              data: NFC_D_CFI};
      end
      NFC_OP_SUSPEND: c = '{wr: 1'b1, addr: '0, data: NFC_D_SUSPEND};
      NFC_OP_RESUME: c = '{wr: 1'b1, addr: '0, data: NFC_D_RESUME};
      NFC_OP_SECT_ADD: c = '{wr: 1'b1, addr: user_addr_in, data: NFC_D_SECTOR};
      NFC_OP_BYP_EXIT1: c = '{wr: 1'b1, addr: '0, data: NFC_D_RESET};
      NFC_OP_BYP_PROG: begin
        len = 3'd2;
        c = (step_in == 3'd0) ? '{wr: 1'b1, addr: '0, data: NFC_D_PROG}
                              : '{wr: 1'b1, addr: user_addr_in, data: user_data_in};
      end
      NFC_OP_BYP_EXIT: begin
        len = 3'd2;
        c = (step_in == 3'd0) ? '{wr: 1'b1, addr: '0, data: NFC_D_IDENT}
                              : '{wr: 1'b1, addr: '0, data: NFC_D_RESET};
      end
      default: begin
        // unlock prefix shared by the long sequences
        len = (op_in == NFC_OP_BYP_ENTER) ? 3'd3 :
              (op_in == NFC_OP_CHIP_ERASE || op_in == NFC_OP_SECT_ERASE) ? 3'd6 : 3'd4;
        unique case (step_in)
          3'd0: c = '{wr: 1'b1, addr: a1, data: NFC_D_UNLOCK1};
          3'd1: c = '{wr: 1'b1, addr: a2, data: NFC_D_UNLOCK2};
          3'd2: c = '{wr: 1'b1, addr: a1, data: (op_in == NFC_OP_IDENT) ? NFC_D_IDENT :
                      (op_in == NFC_OP_PROG) ? NFC_D_PROG : (op_in == NFC_OP_BYP_ENTER) ? NFC_D_BYPASS :
                      NFC_D_SETUP};
          3'd3: c = (op_in == NFC_OP_IDENT) ? '{wr: 1'b0, addr: user_addr_in, data: 8'h00}
                  : (op_in == NFC_OP_PROG) ? '{wr: 1'b1, addr: user_addr_in, data: user_data_in}
                  : '{wr: 1'b1, addr: a1, data: NFC_D_UNLOCK1};
          3'd4: c = '{wr: 1'b1, addr: a2, data: NFC_D_UNLOCK2};
          default: c = (op_in == NFC_OP_SECT_ERASE) ? '{wr: 1'b1, addr: user_addr_in, data: NFC_D_SECTOR}
                     : '{wr: 1'b1, addr: a1, data: NFC_D_CHIP};
        endcase
      end
    endcase
  end
  // registered outputs
  always_ff @(posedge core_clk_in) begin
    cycle_out <= c;
    length_out <= len;
  end
endmodule : nfc_seq_rom
`default_nettype wire

/* File: verilog/nfc_ctrl.sv */
// nfc_ctrl: host side controller that drives nor flash command sequences on the flash pins
// assumes software on the plain register port, one 10 MHz clock, asynchronous flash pins
//
// Behaviour
// - f0 write returns flash to array reads
// - all sequence cycles write, except reads
// - bypass program only after bypass entry
// - bypass exit is 90 then f0
`timescale 1ns/10ps
`default_nettype none
module nfc_ctrl
  import nfc_pkg::*;
#(
  parameter int WINDOW_CYC = NFC_WINDOW_CYC
)(
  input wire logic core_clk_in,
  input wire logic reset_in,
  input wire logic [3:0] reg_addr_in,
  input wire logic [31:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [31:0] reg_rdata_out,
  output logic flash_ce_n_out,
  output logic flash_we_n_out,
  output logic flash_oe_n_out,
  output logic [NFC_ADDR_W-1:0] flash_addr_out,
  output logic [NFC_DATA_W-1:0] flash_dq_out,
  output logic flash_dq_oe_out,
  input wire logic [NFC_DATA_W-1:0] flash_dq_in,
  input wire logic ready_busy_n_output_in
);
  // -----------------------------------------------------------------
  // state
  // -----------------------------------------------------------------
  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001, ST_LOAD = 5'b00010, ST_SETUP = 5'b00100,
    ST_STROBE = 5'b01000, ST_HOLD = 5'b10000
  } nfc_state_type;
  typedef enum logic [4:0] {
    MD_ARRAY = 5'b00001, MD_IDENT = 5'b00010, MD_BYPASS = 5'b00100,
    MD_ERASE = 5'b01000, MD_SUSP = 5'b10000
  } nfc_mode_type;
  nfc_state_type state_r;
  nfc_mode_type mode_r;
  logic [3:0] op_r;
  logic byte_r, err_r, busy_r, cap_r;
  logic [NFC_ADDR_W-1:0] uaddr_r;
  logic [7:0] udata_r;
  logic [NFC_DATA_W-1:0] rdat_r;
  logic [2:0] step_r, ph_r;
  logic [15:0] win_r;
  logic [1:0] rb_sync_r;
  logic [NFC_DATA_W-1:0] dq_s1_r, dq_s2_r;
  nfc_cycle_type cyc;
  logic [2:0] len;
  logic go, legal;
  logic [3:0] go_op;
  logic [3:0] rom_op;
  logic [2:0] rom_step;
  logic rom_byte;

  // table lookahead: the table is registered, so it is fed the op, step and width of the next bus cycle
  assign rom_op = (state_r == ST_IDLE) ? go_op : op_r;
  assign rom_step = (state_r == ST_IDLE) ? 3'h0 : (state_r == ST_HOLD) ? step_r + 3'h1 : step_r;
  assign rom_byte = (state_r == ST_IDLE) ? reg_wdata_in[NFC_CTRL_BYTE] : byte_r;

  nfc_seq_rom u_rom (
    .core_clk_in(core_clk_in), .op_in(rom_op), .step_in(rom_step), .byte_mode_in(rom_byte),
    .user_addr_in(uaddr_r), .user_data_in(udata_r), .cycle_out(cyc), .length_out(len)
  );

  // -----------------------------------------------------------------
  // command legality against the tracked flash mode
  // -----------------------------------------------------------------
  function automatic logic op_legal(input logic [3:0] op, input nfc_mode_type md, input logic win);
    unique case (md)
      MD_BYPASS: op_legal = (op == NFC_OP_BYP_PROG) || (op == NFC_OP_BYP_EXIT)
                            || (op == NFC_OP_BYP_EXIT1) || (op == NFC_OP_READ);
      MD_IDENT: op_legal = (op == NFC_OP_RESET) || (op == NFC_OP_CFI) || (op == NFC_OP_READ);
      MD_ERASE: op_legal = (op == NFC_OP_SUSPEND) || (op == NFC_OP_READ)
                           || ((op == NFC_OP_SECT_ADD) && win);
      MD_SUSP: op_legal = (op == NFC_OP_RESUME) || (op == NFC_OP_READ) || (op == NFC_OP_IDENT)
                          || (op == NFC_OP_PROG) || (op == NFC_OP_RESET);
      default: op_legal = (op != NFC_OP_BYP_PROG) && (op != NFC_OP_BYP_EXIT) && (op != NFC_OP_BYP_EXIT1)
                          && (op != NFC_OP_SUSPEND) && (op != NFC_OP_RESUME) && (op != NFC_OP_SECT_ADD);
    endcase
  endfunction : op_legal

  assign go = reg_wr_in && (reg_addr_in == NFC_REG_CTRL) && reg_wdata_in[NFC_CTRL_GO];
  assign go_op = reg_wdata_in[3:0];
  assign legal = op_legal(go_op, mode_r, win_r != 16'h0000);

  // -----------------------------------------------------------------
  // input synchronisers
  // -----------------------------------------------------------------
  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      rb_sync_r <= 2'h0;
      dq_s1_r <= '0;
      dq_s2_r <= '0;
    end else begin
      rb_sync_r <= {rb_sync_r[0], ready_busy_n_output_in};
      dq_s1_r <= flash_dq_in;
      dq_s2_r <= dq_s1_r;
    end
  end

  // -----------------------------------------------------------------
  // software registers
  // -----------------------------------------------------------------
  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      uaddr_r <= '0;
      udata_r <= 8'h00;
      byte_r <= 1'b0;
    end else begin
      if (reg_wr_in && reg_addr_in == NFC_REG_ADDR) uaddr_r <= reg_wdata_in[NFC_ADDR_W-1:0];
      if (reg_wr_in && reg_addr_in == NFC_REG_DATA) udata_r <= reg_wdata_in[7:0];
      if (go && state_r == ST_IDLE) byte_r <= reg_wdata_in[NFC_CTRL_BYTE];
    end
  end

  // read data, one cycle after the strobe
  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      reg_rdata_out <= 32'h0000_0000;
    end else if (reg_rd_in) begin
      unique case (reg_addr_in)
        NFC_REG_ADDR: reg_rdata_out <= 32'(uaddr_r);
        NFC_REG_DATA: reg_rdata_out <= 32'(udata_r);
        NFC_REG_STAT: reg_rdata_out <= {19'h0, win_r != 16'h0000, rb_sync_r[1], mode_r, err_r, busy_r,
                                        op_r};
        NFC_REG_RDAT: reg_rdata_out <= 32'(rdat_r);
        default: reg_rdata_out <= 32'h0000_0000;
      endcase
    end else begin
      reg_rdata_out <= 32'h0000_0000;
    end
  end

  // -----------------------------------------------------------------
  // sequencer: load, setup, strobe low, hold per bus cycle
  // -----------------------------------------------------------------
  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      state_r <= ST_IDLE;
      op_r <= NFC_OP_READ;
      step_r <= 3'h0;
      ph_r <= 3'h0;
      busy_r <= 1'b0;
      err_r <= 1'b0;
    end else begin
      unique case (state_r)
        ST_IDLE: begin
          if (go) begin
            err_r <= !legal; // refused command sets error, flash untouched
            if (legal) begin
              op_r <= go_op;
              step_r <= 3'h0;
              busy_r <= 1'b1;
              state_r <= ST_LOAD;
            end
          end
        end
        ST_LOAD: begin
          ph_r <= 3'(NFC_PHASE_CYC);
          state_r <= ST_SETUP;
        end
        ST_SETUP: begin
          // address settles before strobe falls
          if (ph_r == 3'h1) begin
            ph_r <= 3'(NFC_PHASE_CYC + 1);
            state_r <= ST_STROBE;
          end else begin
            ph_r <= ph_r - 3'h1;
          end
        end
        ST_STROBE: begin
          if (ph_r == 3'h1) begin
            ph_r <= 3'(NFC_PHASE_CYC);
            state_r <= ST_HOLD;
          end else begin
            ph_r <= ph_r - 3'h1;
          end
        end
        ST_HOLD: begin
          // data held after strobe rises
          if (ph_r == 3'h1) begin
            if (step_r + 3'h1 >= len) begin
              busy_r <= 1'b0;
              state_r <= ST_IDLE;
            end else begin
              step_r <= step_r + 3'h1;
              state_r <= ST_LOAD;
            end
          end else begin
            ph_r <= ph_r - 3'h1;
          end
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  // capture read data one cycle after the read strobe ends, when the synchronised bus still holds it
  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      cap_r <= 1'b0;
      rdat_r <= '0;
    end else begin
      cap_r <= (state_r == ST_HOLD) && (ph_r == 3'(NFC_PHASE_CYC)) && !cyc.wr;
      if (cap_r) rdat_r <= byte_r ? {8'h00, dq_s2_r[7:0]} : dq_s2_r;
    end
  end

  // -----------------------------------------------------------------
  // tracked flash mode and sector erase window
  // -----------------------------------------------------------------
  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      mode_r <= MD_ARRAY;
      win_r <= 16'h0000;
    end else begin
      if (win_r != 16'h0000) win_r <= win_r - 16'h0001;
      if (state_r == ST_HOLD && ph_r == 3'h1 && step_r + 3'h1 >= len) begin
        unique case (op_r)
          NFC_OP_RESET, NFC_OP_BYP_EXIT, NFC_OP_BYP_EXIT1: begin
            mode_r <= (mode_r == MD_SUSP) ? MD_SUSP : MD_ARRAY;
          end
          NFC_OP_IDENT: mode_r <= (mode_r == MD_SUSP) ? MD_SUSP : MD_IDENT;
          NFC_OP_BYP_ENTER: mode_r <= MD_BYPASS;
          NFC_OP_SECT_ERASE, NFC_OP_SECT_ADD: begin
            mode_r <= MD_ERASE;
            win_r <= 16'(WINDOW_CYC);
          end
          NFC_OP_SUSPEND: begin
            mode_r <= MD_SUSP;
            win_r <= 16'h0000;
          end
          NFC_OP_RESUME: mode_r <= MD_ERASE;
          default: mode_r <= mode_r;
        endcase
      end else if (mode_r == MD_ERASE && win_r == 16'h0000 && rb_sync_r[1] && state_r == ST_IDLE) begin
        mode_r <= MD_ARRAY; // erase finished, ready pin high
      end
    end
  end

  // -----------------------------------------------------------------
  // flash pin drive, registered
  // -----------------------------------------------------------------
  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      flash_ce_n_out <= 1'b1;
      flash_we_n_out <= 1'b1;
      flash_oe_n_out <= 1'b1;
      flash_addr_out <= '0;
      flash_dq_out <= '0;
      flash_dq_oe_out <= 1'b0;
    end else begin
      flash_ce_n_out <= !(state_r == ST_SETUP || state_r == ST_STROBE || state_r == ST_HOLD);
      flash_we_n_out <= !(state_r == ST_STROBE && cyc.wr);
      flash_oe_n_out <= !(state_r == ST_STROBE && !cyc.wr);
      if (state_r == ST_LOAD) begin
        // upper byte zero, non-user addresses carry no upper bits
        flash_addr_out <= ((op_r == NFC_OP_SECT_ERASE && step_r + 3'h1 == len) || op_r == NFC_OP_SECT_ADD)
                          ? {uaddr_r[NFC_ADDR_W-1:NFC_SECT_LSB], NFC_SECT_LSB'(0)} : cyc.addr;
        flash_dq_out <= {8'h00, cyc.data};
        flash_dq_oe_out <= cyc.wr;
      end
    end
  end

  // -----------------------------------------------------------------
  // checks
  // -----------------------------------------------------------------
  property p_we_oe_excl;
    @(posedge core_clk_in) disable iff (reset_in) !(!flash_we_n_out && !flash_oe_n_out);
  endproperty
  a_we_oe_excl: assert property (p_we_oe_excl) else $error("we and oe low together");
  property p_upper_zero;
    @(posedge core_clk_in) disable iff (reset_in) !flash_we_n_out |-> flash_dq_out[15:8] == 8'h00;
  endproperty
  a_upper_zero: assert property (p_upper_zero) else $error("upper data byte driven");
  property p_addr_stable;
    @(posedge core_clk_in) disable iff (reset_in) $fell(flash_we_n_out) |-> $stable(flash_addr_out) && !flash_ce_n_out;
  endproperty
  a_addr_stable: assert property (p_addr_stable) else $error("address moved at strobe fall");
  property p_data_hold;
    @(posedge core_clk_in) disable iff (reset_in) $rose(flash_we_n_out) |-> $stable(flash_dq_out) && flash_dq_oe_out;
  endproperty
  a_data_hold: assert property (p_data_hold) else $error("data not held at strobe rise");
  property p_bypass_only;
    @(posedge core_clk_in) disable iff (reset_in)
      (state_r == ST_IDLE && go && mode_r == MD_BYPASS && go_op == NFC_OP_PROG) |=> err_r && state_r == ST_IDLE;
  endproperty
  a_bypass_only: assert property (p_bypass_only) else $error("command taken in bypass mode");
  property p_byp_prog;
    @(posedge core_clk_in) disable iff (reset_in)
      (state_r == ST_IDLE && go && go_op == NFC_OP_BYP_PROG && mode_r != MD_BYPASS) |=> !busy_r;
  endproperty
  a_byp_prog: assert property (p_byp_prog) else $error("bypass program outside bypass");
  property p_suspend;
    @(posedge core_clk_in) disable iff (reset_in)
      (state_r == ST_IDLE && go && go_op == NFC_OP_SUSPEND && mode_r != MD_ERASE) |=> err_r;
  endproperty
  a_suspend: assert property (p_suspend) else $error("suspend outside erase");
  property p_resume;
    @(posedge core_clk_in) disable iff (reset_in)
      (state_r == ST_IDLE && go && go_op == NFC_OP_RESUME && mode_r != MD_SUSP) |=> err_r;
  endproperty
  a_resume: assert property (p_resume) else $error("resume outside suspend");
  property p_window;
    @(posedge core_clk_in) disable iff (reset_in) $rose(win_r != 16'h0000) |-> mode_r == MD_ERASE;
  endproperty
  a_window: assert property (p_window) else $error("window opened outside erase");
endmodule : nfc_ctrl
`default_nettype wire

/* File: bench/nfc_flash_model.sv */
// nfc_flash_model: behavioural word-mode nor flash standing on the controller's pins
// assumes the bench resolves the shared data bus; ready pin is pulled up
`timescale 1ns/10ps
`default_nettype none
module nfc_flash_model
  import nfc_pkg::*;
#(
  parameter logic [15:0] ID_CODE = 16'h1234  // arbitrary value
)(
  input wire logic ce_n_in,
  input wire logic we_n_in,
  input wire logic oe_n_in,
  input wire logic [NFC_ADDR_W-1:0] addr_in,
  input wire logic [NFC_DATA_W-1:0] dq_in,
  output logic [NFC_DATA_W-1:0] dq_out,
  output logic rb_out,
  output logic [7:0] wcnt_out,
  output logic [NFC_ADDR_W-1:0] last_a_out,
  output logic [7:0] last_d_out,
  output logic [7:0] hi_out
);
  logic [15:0] mem [256];
  logic [7:0] h1;
  logic [7:0] h2;
  logic id_mode;
  logic [15:0] rd_v;
  wire act = !ce_n_in && !we_n_in;
  // erased array, idle history
  initial begin
    for (int i = 0; i < 256; i++) mem[i] = 16'hFFFF;
    {wcnt_out, last_a_out, last_d_out, hi_out, h1, h2, id_mode} = '0;
  end
  // address taken when the later of ce and we falls
  always @(posedge act) last_a_out = addr_in;
  // data taken when the first of ce and we rises
  always @(negedge act) begin
    last_d_out = dq_in[7:0];
    hi_out = hi_out | dq_in[15:8];
    wcnt_out = wcnt_out + 8'h01;
    if (h1 == 8'hA0) mem[last_a_out[7:0]] = {8'h00, dq_in[7:0]};
    if (dq_in[7:0] == 8'h90 && h1 == 8'h55 && h2 == 8'hAA) id_mode = 1'b1;
    if (dq_in[7:0] == 8'hF0) id_mode = 1'b0;
    h2 = h1;
    h1 = dq_in[7:0];
  end
  // read path; released bus shows the inverse
  assign rd_v = id_mode ? ((addr_in[7:0] == 8'h00) ? ID_CODE : 16'h0000) : mem[addr_in[7:0]];
  assign dq_out = (!ce_n_in && !oe_n_in) ? rd_v : ~rd_v;
  assign rb_out = 1'b1;
endmodule : nfc_flash_model
`default_nettype wire

/* File: bench/nor_flash_command_decoder_tb_top.sv */
// nor_flash_command_decoder_tb_top: table-driven bench of nfc_ctrl against a flash model
// assumes nfc_pkg register map and the status bit layout of the controller
`timescale 1ns/10ps
`default_nettype none
module nor_flash_command_decoder_tb_top
  import nfc_pkg::*;
;
  typedef struct {logic [3:0] op; logic [19:0] a; logic [7:0] d, n; logic [19:0] ea; logic [7:0] ed;
    logic [15:0] er;} nfc_tb_row_type;
  localparam logic [15:0] ID = 16'h1234;
  logic clk, rst, wr, rd, ce_n, we_n, oe_n, fdoe, rb;
  logic [3:0] ra;
  logic [31:0] wd, rdat, s, n0;
  logic [19:0] fa, la;
  logic [15:0] fdo, mdq, dq_w;
  logic [7:0] wcnt, ld, hi;
  int err_total = 0, check_count = 0, cyc = 0;
  nfc_tb_row_type rows [17] = '{
    '{NFC_OP_PROG, 20'h00012, 8'h5A, 4, 20'h00012, 8'h5A, 0}, '{NFC_OP_READ, 20'h00012, 0, 0, 20'h00012, 8'h5A, 16'h005A},
    '{NFC_OP_IDENT, 0, 0, 3, 20'h00555, 8'h90, ID}, '{NFC_OP_RESET, 0, 0, 1, 20'hFFFFF, 8'hF0, 0},
    '{NFC_OP_IDENT, 20'h01002, 0, 3, 20'h00555, 8'h90, 0}, '{NFC_OP_RESET, 0, 0, 1, 20'hFFFFF, 8'hF0, 0},
    '{NFC_OP_BYP_ENTER, 0, 0, 3, 20'h00555, 8'h20, 0}, '{NFC_OP_BYP_PROG, 20'h00034, 8'hA5, 2, 20'h00034, 8'hA5, 0},
    '{NFC_OP_BYP_EXIT, 0, 0, 2, 20'hFFFFF, 8'hF0, 0}, '{NFC_OP_BYP_ENTER, 0, 0, 3, 20'h00555, 8'h20, 0},
    '{NFC_OP_BYP_EXIT1, 0, 0, 1, 20'hFFFFF, 8'hF0, 0}, '{NFC_OP_CFI, 0, 0, 1, 20'h00055, 8'h98, 0},
    '{NFC_OP_RESET, 0, 0, 1, 20'hFFFFF, 8'hF0, 0}, '{NFC_OP_CHIP_ERASE, 0, 0, 6, 20'h00555, 8'h10, 0},
    '{NFC_OP_SECT_ERASE, 20'h23456, 0, 6, 20'h23000, 8'h30, 0}, '{NFC_OP_SUSPEND, 0, 0, 1, 20'hFFFFF, 8'hB0, 0},
    '{NFC_OP_RESUME, 0, 0, 1, 20'hFFFFF, 8'h30, 0}};
  assign dq_w = fdoe ? fdo : mdq;
  nfc_ctrl #(.WINDOW_CYC(200)) dut (.core_clk_in(clk), .reset_in(rst), .reg_addr_in(ra), .reg_wdata_in(wd),
    .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdat), .flash_ce_n_out(ce_n), .flash_we_n_out(we_n),
    .flash_oe_n_out(oe_n), .flash_addr_out(fa), .flash_dq_out(fdo), .flash_dq_oe_out(fdoe),
    .flash_dq_in(dq_w), .ready_busy_n_output_in(rb));
  nfc_flash_model #(.ID_CODE(ID)) model (.ce_n_in(ce_n), .we_n_in(we_n), .oe_n_in(oe_n), .addr_in(fa),
    .dq_in(dq_w), .dq_out(mdq), .rb_out(rb), .wcnt_out(wcnt), .last_a_out(la), .last_d_out(ld), .hi_out(hi));
  // clock and hang guard
  initial clk = 1'b0;
  always #50 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      final_report();
    end
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic wreg(input logic [3:0] a, input logic [31:0] v);
    @(posedge clk);
    ra <= a;
    wd <= v;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wreg
  task automatic rreg(input logic [3:0] a, output logic [31:0] v);
    @(posedge clk);
    ra <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 v = rdat;
  endtask : rreg
  // load address and data, start the op, poll busy with a bound
  task automatic run_op(input logic [3:0] op, input logic [19:0] a, input logic [7:0] d);
    wreg(NFC_REG_ADDR, {12'h000, a});
    wreg(NFC_REG_DATA, {24'h000000, d});
    wreg(NFC_REG_CTRL, {26'h0, 2'b01, op});
    s = 32'h10;
    for (int i = 0; i < 100 && s[4] !== 1'b0; i++) rreg(NFC_REG_STAT, s);
    chk(s[4], 0);
  endtask : run_op
  task automatic final_report;
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : final_report
  // main sequence: reset, table rows, refusals, mid-op reset
  initial begin
    {rst, wr, rd, ra, wd} = {1'b1, 2'b00, 4'h0, 32'h0};
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    #1 chk({ce_n, we_n, oe_n, fdoe}, 4'hE);
    for (int i = 0; i < 17; i++) begin
      n0 = wcnt;
      run_op(rows[i].op, rows[i].a, rows[i].d);
      chk(8'(wcnt - n0[7:0]), rows[i].n);
      chk(ld, rows[i].ed);
      if (rows[i].ea !== 20'hFFFFF) chk(la, rows[i].ea);
      if (rows[i].op == NFC_OP_READ || rows[i].op == NFC_OP_IDENT) begin
        rreg(NFC_REG_RDAT, s);
        chk(s, {16'h0, rows[i].er});
      end
      if (rows[i].op == NFC_OP_CHIP_ERASE || rows[i].op == NFC_OP_RESUME) repeat (250) @(posedge clk);
      $display("row %0d done", i);
    end
    chk(hi, 0);
    n0 = wcnt;
    run_op(NFC_OP_SUSPEND, 0, 0);
    chk(s[5], 1);
    run_op(NFC_OP_BYP_PROG, 20'h00040, 8'h11);
    chk(s[5], 1);
    chk(wcnt, n0);
    rreg(4'hF, s);
    chk(s, 0);
    $display("refusal tests done");
    wreg(NFC_REG_ADDR, 32'h0);
    wreg(NFC_REG_CTRL, {26'h0, 2'b11, NFC_OP_IDENT});
    repeat (40) @(posedge clk);
    chk(la, 20'h00AAA);
    rreg(NFC_REG_RDAT, s);
    chk(s, {24'h0, ID[7:0]});
    run_op(NFC_OP_RESET, 0, 0);
    $display("byte mode test done");
    wreg(NFC_REG_CTRL, {26'h0, 2'b01, NFC_OP_PROG});
    repeat (3) @(posedge clk);
    rst <= 1'b1;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    rreg(NFC_REG_STAT, s);
    chk({ce_n, we_n, oe_n, fdoe, s[4]}, 5'h1C);
    $display("reset test done");
    final_report();
  end
endmodule : nor_flash_command_decoder_tb_top
`default_nettype wire
